// ==== logic/psg_map.svh ====
// register indices, field values and reply figures of the settings read-back mailbox
`ifndef PSG_MAP_SVH
`define PSG_MAP_SVH
`define PSG_IDX_REQ_CODE 14'h1F3F
`define PSG_IDX_REQ_COUNT 14'h1F40
`define PSG_IDX_REQ_DEST 14'h1F41
`define PSG_IDX_REQ_SEC 14'h1F42
`define PSG_IDX_REQ_PWD_HI 14'h1F43
`define PSG_IDX_REQ_PWD_LO 14'h1F44
`define PSG_IDX_REQ_KEY_HI 14'h1F45
`define PSG_IDX_REQ_KEY_LO 14'h1F46
`define PSG_IDX_REQ_EXTRA 14'h1F47
`define PSG_IDX_CTRL 14'h1F50
`define PSG_IDX_REP_CODE 14'h1F53
`define PSG_IDX_REP_STATUS 14'h1F54
`define PSG_IDX_REP_COUNT 14'h1F55
`define PSG_IDX_REP_KEY_HI 14'h1F56
`define PSG_IDX_REP_KEY_LO 14'h1F57
`define PSG_IDX_PAY_BASE 14'h1F58
`define PSG_PAY_WORDS 24
`define PSG_CODE_EARTH 16'hC984
`define PSG_CODE_NEUTRAL 16'hC985
`define PSG_COUNT_EARTH 16'h0010
`define PSG_COUNT_NEUTRAL 16'h000E
`define PSG_DEST 16'h1501
`define PSG_KEY_MAX 32'hFFFFFFFE
`define PSG_BYTES_EARTH 16'h0034
`define PSG_BYTES_NEUTRAL 16'h0020
`define PSG_EARTH_FILL 16'hFFFF
`define PSG_ST_OK 16'h0000
`define PSG_ST_BAD_CODE 16'h0001
`define PSG_ST_BAD_COUNT 16'h0002
`define PSG_ST_BAD_DEST 16'h0003
`define PSG_ST_BAD_SEC 16'h0004
`define PSG_ST_BAD_KEY 16'h0005
`define PSG_ST_BAD_DELAY 16'h0006
`define PSG_DLY_006 32'h3D75C28F
`define PSG_DLY_015 32'h3E19999A
`define PSG_DLY_023 32'h3E6B851F
`define PSG_DLY_035 32'h3EB33333
`define PSG_DLY_080 32'h3F4CCCCD
`define PSG_CTRL_START_BIT 0
`define PSG_CTRL_DONE_BIT 1
`define PSG_RESP_OKAY 2'h0
`define PSG_RESP_SLVERR 2'h2
`endif

// ==== logic/psg_pkg.sv ====
// types shared by the settings read-back mailbox
package psg_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_FILL, ST_DONE} psg_state_e;
  typedef logic [15:0] psg_word_t;
endpackage : psg_pkg

// ==== logic/psg_top.sv ====
// protection settings read-back command mailbox behind an axi4-lite slave
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// What this block does
// - zero security and password mean none
// - session key echoed into reply words
// - executed command code echoed in reply
// - status zero on success, else nonzero
// - byte count 52 earth, 32 neutral
// - earth word0 0xFFFF, word1 mode/supported
// - earth reply carries two timestamps, qualities
// - earth reply carries two float high limits
// - earth threshold and restricted time delay
// - neutral word0 holds mode and supported
// - neutral reply carries two timestamps, qualities
// - neutral type word, zero upper byte
// - neutral reply ends with long-time threshold
`include "psg_map.svh"
module psg_top #(
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic el_mode_on,
  input wire logic el_supported,
  input wire logic [63:0] el_mode_stamp,
  input wire logic [15:0] el_mode_quality,
  input wire logic [63:0] el_param_stamp,
  input wire logic [15:0] el_param_quality,
  input wire logic [31:0] el_coef_high_limit,
  input wire logic [31:0] el_delay_high_limit,
  input wire logic [31:0] el_threshold,
  input wire logic [31:0] el_delay,
  input wire logic nt_mode_on,
  input wire logic nt_supported,
  input wire logic [63:0] nt_mode_stamp,
  input wire logic [15:0] nt_mode_quality,
  input wire logic [63:0] nt_param_stamp,
  input wire logic [15:0] nt_param_quality,
  input wire logic [1:0] nt_type,
  input wire logic [31:0] nt_lt_threshold,
  output logic busy
);
  import psg_pkg::*;
  psg_state_e state_r;
  psg_word_t req_code_r, req_count_r, req_dest_r, req_sec_r, req_extra_r;
  psg_word_t rep_code_r, rep_status_r, rep_count_r, err_r, err_nxt;
  logic [31:0] req_pwd_r, req_key_r, rep_key_r, wdata_r;
  psg_word_t pay_r [`PSG_PAY_WORDS], pay_nxt [`PSG_PAY_WORDS];
  logic done_r, aw_got_r, w_got_r;
  logic [13:0] aw_idx_r, ar_idx, pay_rel;
  logic [3:0] wstrb_r;
  logic wr_do, start, req_hit, delay_ok;

  // a write is carried out once both address and data have been taken
  assign wr_do = aw_got_r && w_got_r && !s_axi_bvalid;
  assign req_hit = (aw_idx_r >= `PSG_IDX_REQ_CODE) && (aw_idx_r <= `PSG_IDX_REQ_EXTRA);
  assign start = wr_do && (aw_idx_r == `PSG_IDX_CTRL) && wstrb_r[0] && wdata_r[`PSG_CTRL_START_BIT]
                 && (state_r == ST_IDLE);

  // write address and data channels, taken in either order
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_idx_r <= 14'h0000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_idx_r <= s_axi_awaddr[15:2];
        aw_got_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_got_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write response; request words are locked while a command runs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PSG_RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid <= 1'b1;
      if ((req_hit && state_r == ST_IDLE) || aw_idx_r == `PSG_IDX_CTRL)
        s_axi_bresp <= `PSG_RESP_OKAY;
      else
        s_axi_bresp <= `PSG_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // request block storage, low two byte lanes only
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      req_code_r <= 16'h0000;
      req_count_r <= 16'h0000;
      req_dest_r <= 16'h0000;
      req_sec_r <= 16'h0000;
      req_pwd_r <= 32'h00000000;
      req_key_r <= 32'h00000000;
      req_extra_r <= 16'h0000;
    end
    else if (wr_do && req_hit && state_r == ST_IDLE)
    begin
      for (int b = 0; b < 2; b++)
      begin
        if (wstrb_r[b])
        begin
          unique case (aw_idx_r)
            `PSG_IDX_REQ_CODE: req_code_r[8*b +: 8] <= wdata_r[8*b +: 8];
            `PSG_IDX_REQ_COUNT: req_count_r[8*b +: 8] <= wdata_r[8*b +: 8];
            `PSG_IDX_REQ_DEST: req_dest_r[8*b +: 8] <= wdata_r[8*b +: 8];
            `PSG_IDX_REQ_SEC: req_sec_r[8*b +: 8] <= wdata_r[8*b +: 8];
            `PSG_IDX_REQ_PWD_HI: req_pwd_r[16+8*b +: 8] <= wdata_r[8*b +: 8];
            `PSG_IDX_REQ_PWD_LO: req_pwd_r[8*b +: 8] <= wdata_r[8*b +: 8];
            `PSG_IDX_REQ_KEY_HI: req_key_r[16+8*b +: 8] <= wdata_r[8*b +: 8];
            `PSG_IDX_REQ_KEY_LO: req_key_r[8*b +: 8] <= wdata_r[8*b +: 8];
            default: req_extra_r[8*b +: 8] <= wdata_r[8*b +: 8];
          endcase
        end
      end
    end
  end

  // the delay may only take one of five float codes
  assign delay_ok = (el_delay == `PSG_DLY_006) || (el_delay == `PSG_DLY_015) || (el_delay == `PSG_DLY_023)
                    || (el_delay == `PSG_DLY_035) || (el_delay == `PSG_DLY_080);

  // request check, first failing field decides the status
  always_comb
  begin
    err_nxt = `PSG_ST_OK;
    if (req_code_r != `PSG_CODE_EARTH && req_code_r != `PSG_CODE_NEUTRAL)
      err_nxt = `PSG_ST_BAD_CODE;
    else if ((req_code_r == `PSG_CODE_EARTH && req_count_r != `PSG_COUNT_EARTH)
             || (req_code_r == `PSG_CODE_NEUTRAL && req_count_r != `PSG_COUNT_NEUTRAL))
      err_nxt = `PSG_ST_BAD_COUNT;
    else if (req_dest_r != `PSG_DEST)
      err_nxt = `PSG_ST_BAD_DEST;
    else if (req_sec_r != 16'h0000 || req_pwd_r != 32'h00000000)
      err_nxt = `PSG_ST_BAD_SEC;
    else if (req_key_r > `PSG_KEY_MAX)
      err_nxt = `PSG_ST_BAD_KEY;
    else if (req_code_r == `PSG_CODE_EARTH && !delay_ok)
      err_nxt = `PSG_ST_BAD_DELAY;
  end

  // payload image; unused tail words read as zero
  always_comb
  begin
    for (int i = 0; i < `PSG_PAY_WORDS; i++)
      pay_nxt[i] = 16'h0000;
    if (req_code_r == `PSG_CODE_EARTH)
    begin
      pay_nxt[0] = `PSG_EARTH_FILL;
      pay_nxt[1] = {7'h00, el_mode_on, 7'h00, el_supported};
      for (int i = 0; i < 4; i++)
      begin
        pay_nxt[2+i] = el_mode_stamp[63-16*i -: 16];
        pay_nxt[7+i] = el_param_stamp[63-16*i -: 16];
      end
      pay_nxt[6] = el_mode_quality;
      pay_nxt[11] = el_param_quality;
      pay_nxt[12] = el_coef_high_limit[31:16];
      pay_nxt[13] = el_coef_high_limit[15:0];
      pay_nxt[14] = el_delay_high_limit[31:16];
      pay_nxt[15] = el_delay_high_limit[15:0];
      pay_nxt[16] = el_threshold[31:16];
      pay_nxt[17] = el_threshold[15:0];
      pay_nxt[18] = el_delay[31:16];
      pay_nxt[19] = el_delay[15:0];
    end
    else
    begin
      pay_nxt[0] = {7'h00, nt_mode_on, 7'h00, nt_supported};
      for (int i = 0; i < 4; i++)
      begin
        pay_nxt[1+i] = nt_mode_stamp[63-16*i -: 16];
        pay_nxt[6+i] = nt_param_stamp[63-16*i -: 16];
      end
      pay_nxt[5] = nt_mode_quality;
      pay_nxt[10] = nt_param_quality;
      pay_nxt[11] = {8'h00, 6'h00, nt_type};
      pay_nxt[12] = nt_lt_threshold[31:16];
      pay_nxt[13] = nt_lt_threshold[15:0];
    end
  end

  // command sequencer: check, fill payload, then commit header words
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      err_r <= 16'h0000;
      busy <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (start)
          begin
            state_r <= ST_CHECK;
            busy <= 1'b1;
          end
        ST_CHECK:
        begin
          err_r <= err_nxt;
          state_r <= ST_FILL;
        end
        ST_FILL: state_r <= ST_DONE;
        ST_DONE:
        begin
          state_r <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
  // payload words change only for an accepted request
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < `PSG_PAY_WORDS; i++)
        pay_r[i] <= 16'h0000;
    end
    else if (state_r == ST_FILL && err_r == `PSG_ST_OK)
    begin
      for (int i = 0; i < `PSG_PAY_WORDS; i++)
        pay_r[i] <= pay_nxt[i];
    end
  end
  // header words land one cycle after the payload is complete
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rep_code_r <= 16'h0000;
      rep_status_r <= 16'h0000;
      rep_count_r <= 16'h0000;
      rep_key_r <= 32'h00000000;
      done_r <= 1'b0;
    end
    else if (state_r == ST_DONE)
    begin
      rep_code_r <= req_code_r;
      rep_status_r <= err_r;
      rep_key_r <= req_key_r;
      done_r <= 1'b1;
      if (err_r != `PSG_ST_OK)
        rep_count_r <= 16'h0000;
      else if (req_code_r == `PSG_CODE_EARTH)
        rep_count_r <= `PSG_BYTES_EARTH;
      else
        rep_count_r <= `PSG_BYTES_NEUTRAL;
    end
    else if (start)
      done_r <= 1'b0;
  end
  // read channel, one cycle from address to data
  assign ar_idx = s_axi_araddr[15:2];
  assign pay_rel = ar_idx - `PSG_IDX_PAY_BASE;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PSG_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `PSG_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      if (ar_idx >= `PSG_IDX_PAY_BASE && pay_rel < 14'(`PSG_PAY_WORDS))
        s_axi_rdata[15:0] <= pay_r[pay_rel[4:0]];
      else
      begin
        unique case (ar_idx)
          `PSG_IDX_REQ_CODE: s_axi_rdata[15:0] <= req_code_r;
          `PSG_IDX_REQ_COUNT: s_axi_rdata[15:0] <= req_count_r;
          `PSG_IDX_REQ_DEST: s_axi_rdata[15:0] <= req_dest_r;
          `PSG_IDX_REQ_SEC: s_axi_rdata[15:0] <= req_sec_r;
          `PSG_IDX_REQ_PWD_HI: s_axi_rdata[15:0] <= req_pwd_r[31:16];
          `PSG_IDX_REQ_PWD_LO: s_axi_rdata[15:0] <= req_pwd_r[15:0];
          `PSG_IDX_REQ_KEY_HI: s_axi_rdata[15:0] <= req_key_r[31:16];
          `PSG_IDX_REQ_KEY_LO: s_axi_rdata[15:0] <= req_key_r[15:0];
          `PSG_IDX_REQ_EXTRA: s_axi_rdata[15:0] <= req_extra_r;
          `PSG_IDX_CTRL: s_axi_rdata[1:0] <= {done_r, busy};
          `PSG_IDX_REP_CODE: s_axi_rdata[15:0] <= rep_code_r;
          `PSG_IDX_REP_STATUS: s_axi_rdata[15:0] <= rep_status_r;
          `PSG_IDX_REP_COUNT: s_axi_rdata[15:0] <= rep_count_r;
          `PSG_IDX_REP_KEY_HI: s_axi_rdata[15:0] <= rep_key_r[31:16];
          `PSG_IDX_REP_KEY_LO: s_axi_rdata[15:0] <= rep_key_r[15:0];
          default: s_axi_rresp <= `PSG_RESP_SLVERR; // unmapped index
        endcase
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // checks on the sequencer and reply words
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_start_sequence: assert property (start |=> state_r == ST_CHECK ##1 state_r == ST_FILL
                                     ##1 state_r == ST_DONE ##1 state_r == ST_IDLE)
    else $error("command sequence out of order");
  a_status_hold: assert property (state_r != ST_DONE |=> $stable(rep_status_r) && $stable(rep_count_r))
    else $error("status changed outside commit");
  a_key_echo: assert property (state_r == ST_DONE |=> rep_key_r == $past(req_key_r))
    else $error("session key not echoed");
  a_code_echo: assert property (state_r == ST_DONE |=> rep_code_r == $past(req_code_r))
    else $error("command code not echoed");
  a_status_error: assert property (state_r == ST_DONE && err_r != 16'h0000 |=> rep_status_r != 16'h0000)
    else $error("failed command shows zero status");
  a_count_earth: assert property (state_r == ST_DONE && err_r == 16'h0000 && req_code_r == 16'hC984
                                  |=> rep_count_r == 16'h0034 && rep_status_r == 16'h0000)
    else $error("earth byte count wrong");
  a_earth_fill: assert property (state_r == ST_FILL && err_r == 16'h0000 && req_code_r == 16'hC984
                                 |=> pay_r[0] == 16'hFFFF && pay_r[1][15:9] == 7'h00)
    else $error("earth word0 not filled");
  a_neutral_type: assert property (state_r == ST_FILL && err_r == 16'h0000 && req_code_r == 16'hC985
                                   |=> pay_r[11] == {14'h0000, $past(nt_type)})
    else $error("neutral type word wrong");
  a_secure_reject: assert property (start ##1 (req_sec_r != 16'h0000 && req_code_r == 16'hC984
                                    && req_count_r == 16'h0010 && req_dest_r == 16'h1501)
                                    |-> ##3 rep_status_r != 16'h0000)
    else $error("nonzero security accepted");
  a_reject_payload: assert property (state_r == ST_FILL && err_r != 16'h0000
                                     |=> $stable(pay_r[0]) && $stable(pay_r[12]))
    else $error("rejected request touched payload");
  c_earth_ok: cover property (state_r == ST_DONE && err_r == 16'h0000 && req_code_r == 16'hC984);
  c_neutral_ok: cover property (state_r == ST_DONE && err_r == 16'h0000 && req_code_r == 16'hC985);
  c_rejected: cover property (state_r == ST_DONE && err_r != 16'h0000);
  c_refused_write: cover property (wr_do && req_hit && state_r != ST_IDLE);
endmodule : psg_top

// ==== testbench/psg_axi_master.sv ====
// axi4-lite master model standing in for the remote host
`timescale 1ns/1ns
module psg_axi_master (
  input wire logic clk,
  output logic [15:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [15:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // quiet bus at time zero
  initial
  begin
    s_axi_awaddr = 16'h0000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 16'h0000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  // one word write, address and data offered together, each dropped once taken
  task automatic wr(input logic [13:0] idx, input logic [15:0] d, output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {~d, d}; // upper lanes carry noise the slave must ignore
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (!aw_ok && s_axi_awready === 1'b1)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~s_axi_awaddr; // released lines never keep the last value
      end
      if (!w_ok && s_axi_wready === 1'b1)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~s_axi_wdata;
      end
    end
    do
      @(posedge clk);
    while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // one word read, ready held until the data is seen
  task automatic rd(input logic [13:0] idx, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
      @(posedge clk);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~s_axi_araddr;
    while (s_axi_rvalid !== 1'b1)
      @(posedge clk);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : psg_axi_master

// ==== testbench/psg_top_tb_top.sv ====
// self-checking bench for the settings read-back mailbox
`timescale 1ns/1ns
`include "psg_map.svh"
module psg_top_tb_top;
  import psg_pkg::*;
  logic clk;
  logic resetn;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, busy;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic el_mode_on, el_supported, nt_mode_on, nt_supported;
  logic [63:0] el_mode_stamp, el_param_stamp, nt_mode_stamp, nt_param_stamp;
  logic [15:0] el_mode_quality, el_param_quality, nt_mode_quality, nt_param_quality;
  logic [31:0] el_coef_high_limit, el_delay_high_limit, el_threshold, el_delay, nt_lt_threshold;
  logic [1:0] nt_type;
  logic [383:0] pay_exp;
  logic [31:0] key, d;
  logic [1:0] r;
  int bad_count, checks_done, i;
  // five legal delay codes, then 1.0 s which is not allowed
  logic [31:0] dly_tab [6] = '{32'h3D75C28F, 32'h3E19999A, 32'h3E6B851F, 32'h3EB33333, 32'h3F4CCCCD, 32'h3F800000};

  psg_top dut (
    .clk, .resetn, .s_axi_awaddr, .s_axi_awprot(3'b000), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'b000), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .el_mode_on, .el_supported, .el_mode_stamp, .el_mode_quality, .el_param_stamp,
    .el_param_quality, .el_coef_high_limit, .el_delay_high_limit, .el_threshold, .el_delay, .nt_mode_on,
    .nt_supported, .nt_mode_stamp, .nt_mode_quality, .nt_param_stamp, .nt_param_quality, .nt_type,
    .nt_lt_threshold, .busy
  );

  psg_axi_master m (
    .clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // fresh random settings sources, delay picked from the table
  task automatic set_src(input int di, input logic [1:0] ty);
    {el_mode_on, el_supported, nt_mode_on, nt_supported} <= 4'($urandom);
    nt_type <= ty;
    {el_mode_stamp, el_param_stamp} <= {$urandom, $urandom, $urandom, $urandom};
    {nt_mode_stamp, nt_param_stamp} <= {$urandom, $urandom, $urandom, $urandom};
    {el_mode_quality, el_param_quality, nt_mode_quality, nt_param_quality} <= {$urandom, $urandom};
    {el_coef_high_limit, el_delay_high_limit} <= {$urandom, $urandom};
    {el_threshold, nt_lt_threshold} <= {$urandom, $urandom};
    el_delay <= dly_tab[di];
  endtask : set_src

  // expected 24 payload words, first word in the top bits
  function automatic logic [383:0] exp_pay(input logic earth);
    if (earth)
      return {16'hFFFF, 7'h00, el_mode_on, 7'h00, el_supported, el_mode_stamp, el_mode_quality, el_param_stamp,
        el_param_quality, el_coef_high_limit, el_delay_high_limit, el_threshold, el_delay, 64'h0};
    return {7'h00, nt_mode_on, 7'h00, nt_supported, nt_mode_stamp, nt_mode_quality, nt_param_stamp,
      nt_param_quality, 14'h0000, nt_type, nt_lt_threshold, 160'h0};
  endfunction : exp_pay

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // full request, start, poll for done, then read back the whole reply block
  task automatic cmd(input logic [15:0] code, cnt, dest, sec, input logic [31:0] k, input logic [15:0] st, bytes,
    input logic earth);
    logic [1:0] rr;
    logic [31:0] dd;
    logic [15:0] req [9];
    logic [15:0] hdr [5];
    int j;
    req = '{code, cnt, dest, sec, 16'h0000, 16'h0000, k[31:16], k[15:0], 16'hFFFF};
    hdr = '{code, st, bytes, k[31:16], k[15:0]};
    for (j = 0; j < 9; j++)
    begin
      m.wr(`PSG_IDX_REQ_CODE + 14'(j), req[j], rr);
      chk(rr, 32'h0);
    end
    m.rd(`PSG_IDX_REQ_CODE, dd, rr);
    chk(dd, {16'h0000, code}); // request code word read back
    m.wr(`PSG_IDX_CTRL, 16'h0001, rr);
    dd = 32'h0;
    while (dd[1] !== 1'b1)
      m.rd(`PSG_IDX_CTRL, dd, rr);
    if (st === 16'h0000)
      pay_exp = exp_pay(earth);
    for (j = 0; j < 29; j++)
    begin
      m.rd(`PSG_IDX_REP_CODE + 14'(j), dd, rr);
      if (j < 5)
        chk(dd, {16'h0000, hdr[j]});
      else
        chk(dd, {16'h0000, pay_exp[383 - 16 * (j - 5) -: 16]});
    end
  endtask : cmd

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // watchdog, far beyond the expected few thousand cycles
  initial
  begin
    repeat (30000) @(posedge clk);
    bad_count++;
    test_done();
  end

  // main sequence
  initial
  begin
    bad_count = 0;
    checks_done = 0;
    resetn = 1'b0;
    pay_exp = '0;
    void'($urandom(32'hBC0E7E98));
    set_src(0, 2'h0);
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    m.rd(`PSG_IDX_REQ_CODE, d, r);
    chk(d, 32'h0);
    m.rd(`PSG_IDX_REP_COUNT, d, r);
    chk(d, 32'h0);
    chk(busy, 1'b0);
    $display("test reset done");
    // earth leakage, every legal delay, key at its top limit first
    for (i = 0; i < 5; i++)
    begin
      @(posedge clk);
      set_src(i, 2'(i));
      key = (i == 0) ? 32'hFFFFFFFE : $urandom % 32'hFFFFFFFF;
      cmd(16'hC984, 16'h0010, 16'h1501, 16'h0000, key, 16'h0000, 16'h0034, 1'b1);
    end
    $display("test earth done");
    // neutral, every neutral type, key zero first
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      set_src(i, 2'(i));
      key = (i == 0) ? 32'h0 : $urandom % 32'hFFFFFFFF;
      cmd(16'hC985, 16'h000E, 16'h1501, 16'h0000, key, 16'h0000, 16'h0020, 1'b0);
    end
    $display("test neutral done");
    // one faulty field at a time; payload must keep the last good reply
    for (i = 0; i < 6; i++)
    begin
      @(posedge clk);
      set_src(i, 2'(i));
      cmd(i == 0 ? 16'h1234 : 16'hC984, i == 1 ? 16'h000E : 16'h0010, i == 2 ? 16'h1502 : 16'h1501,
        i == 3 ? 16'h0001 : 16'h0000, i == 4 ? 32'hFFFFFFFF : 32'h1, 16'(i + 1), 16'h0000, 1'b1);
    end
    $display("test errors done");
    // reply words are read-only, unmapped index refused
    m.wr(`PSG_IDX_REP_STATUS, 16'h5A5A, r);
    chk(r, 32'h2);
    m.rd(`PSG_IDX_REP_STATUS, d, r);
    chk(d, 32'h6);
    m.rd(14'h1F48, d, r);
    chk(r, 32'h2);
    chk(d, 32'h0);
    $display("test refusals done");
    test_done();
  end
endmodule : psg_top_tb_top
